// ---- common/esr_pkg.sv ----
// Package of constants and carriers for the event status reporting block
package esr_pkg;
    // Event status bit positions
    localparam int EV_OPC = 0;
    localparam int EV_QUERY = 2;
    localparam int EV_DEVICE = 3;
    localparam int EV_EXEC = 4;
    localparam int EV_CMD = 5;
    localparam int EV_USER = 6;
    localparam int EV_PWR = 7;
    // Operation status bit positions
    localparam int OP_CAL = 0;
    localparam int OP_SWEEP = 3;
    localparam int OP_MEAS = 4;
    localparam int OP_TRIG = 5;
    localparam int OP_HCOPY = 8;
    localparam int OP_RANGE = 10;
    localparam int OP_ZERO = 15;
    // Implemented-bit masks; other bits of the event latch and operation condition and event views read zero
    localparam logic [7:0] EV_USED = 8'hFD;
    localparam logic [15:0] OP_USED = 16'h0539;
    // Reset values
    localparam logic [7:0] EV_RESET = 8'h80;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [15:0] OP_RESET = 16'h0000;
    // Error code ranges
    localparam int DEV_ERR_LO = -399;
    localparam int DEV_ERR_HI = -300;
    localparam int EXE_ERR_LO = -300;
    localparam int EXE_ERR_HI = -200;
    localparam int CMD_ERR_LO = -200;
    localparam int CMD_ERR_HI = -100;
    localparam int ERR_W = 16;
    localparam logic signed [15:0] DEV_ERR_CODE = -16'sd300;
    localparam logic signed [15:0] EXE_ERR_CODE = -16'sd200;
    localparam logic signed [15:0] CMD_ERR_CODE = -16'sd100;

    // Command channel events from the parser
    typedef struct packed {
        logic opcReq;
        logic readNoQuery;
        logic unreadOverrun;
        logic devErr;
        logic signed [15:0] devCode;
        logic execErr;
        logic cmdErr;
    } esr_cmd_s;

    // Live instrument activity
    typedef struct packed {
        logic alignmentInProgress;
        logic sweepActiveFlag;
        logic acquisitionActive;
        logic armedWaiting;
        logic hardcopyBusy;
        logic rangeDone;
    } esr_act_s;

    // Register access strobes
    typedef struct packed {
        logic maskWr;
        logic [7:0] maskData;
        logic opEnWr;
        logic [15:0] opEnData;
        logic evRd;
        logic opEvRd;
    } esr_acc_s;
endpackage

// ---- core/esr_status_core.sv ----
// Event status latch, enable mask and operation status registers
// Functional notes
// - Operation complete set only after all earlier commands finished.
// - Query error bit 2 on unrequested read or unread response.
// - Device error sets bit 3, queues code -300 to -399 or positive.
// - Execution error sets bit 4, queues code -200 to -300.
// - Command error sets bit 5, queues code -100 to -200.
// - Local key request sets bit 6.
// - Power-on sets bit 7 so first read shows it.
// - Writable event enable mask, one bit per event bit.
// - Event status query returns latched event bits.
// - Operation bit 0 high throughout calibration.
// - Operation bits 3 and 4 identical, high during sweep or measurement.
// - Operation bit 5 high while armed for trigger.
// - Operation bit 8 high during hardcopy.
// - Operation bit 10 set per completed range when stop-after-range enabled.
// - Operation bit 15 always zero.
// - Operation status readable as condition and as latched event view.
// - Latched operation events persist until read, even if ended.
// - Reading a latched event part clears it.
// - Event summary is OR of event bits ANDed with mask.
// - Operation summary is OR of operation events ANDed with enables.
`timescale 1ns/1ps
module esr_status_core
#(
    // Width of the queued error code; the packed carrier fixes it at 16
    parameter int CODE_W = esr_pkg::ERR_W,
    // Register widths; the bit map below only fits these
    parameter int EV_W = 8,
    parameter int OP_W = 16
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Command channel
    input wire esr_pkg::esr_cmd_s cmdEv,
    input wire logic pendingDone,
    input wire logic localKey,
    // Activity and options
    input wire esr_pkg::esr_act_s act,
    input wire logic stopAfterRange,
    // Register access
    input wire esr_pkg::esr_acc_s acc,
    // Read views
    output logic [7:0] eventStatusLatch,
    output logic [7:0] eventStatusMask,
    output logic [15:0] opCondition,
    output logic [15:0] opEvent,
    output logic [15:0] opEnable,
    // Summaries
    output logic eventSummaryFlag,
    output logic opSummary,
    // Error queue push
    output logic errPush,
    output logic signed [15:0] errCode
);
    logic [7:0] ev_q, ev_d, mask_q, evSet;
    logic [15:0] cond_q, cond_d, opEv_q, opEv_d, opEn_q, rise;
    logic opcWait_q, opcWait_d, key_q, push_q, push_d;
    logic signed [15:0] code_q, code_d;
    logic evSum_q, opSum_q;

    // Elaboration checks; other widths would break the fixed bit map
    if (CODE_W != 16)
    begin : g_code_w_check
        $error("esr_status_core: CODE_W must be 16");
    end
    if (EV_W != 8)
    begin : g_ev_w_check
        $error("esr_status_core: EV_W must be 8");
    end
    if (OP_W != 16)
    begin : g_op_w_check
        $error("esr_status_core: OP_W must be 16");
    end

    // Mask bits to implemented positions only
    function automatic logic [15:0] opMasked(input logic [15:0] v);
        return v & esr_pkg::OP_USED;
    endfunction

    // OPC is held pending until the parser reports all earlier commands done
    assign opcWait_d = (opcWait_q | cmdEv.opcReq) & ~pendingDone;
    // Event sources; unused bit 1 never set
    assign evSet[esr_pkg::EV_OPC] = (opcWait_q | cmdEv.opcReq) & pendingDone;
    assign evSet[1] = 1'b0;
    assign evSet[esr_pkg::EV_QUERY] = cmdEv.readNoQuery | cmdEv.unreadOverrun;
    assign evSet[esr_pkg::EV_DEVICE] = cmdEv.devErr;
    assign evSet[esr_pkg::EV_EXEC] = cmdEv.execErr;
    assign evSet[esr_pkg::EV_CMD] = cmdEv.cmdErr;
    assign evSet[esr_pkg::EV_USER] = localKey & ~key_q;
    assign evSet[esr_pkg::EV_PWR] = 1'b0;
    // Set wins over read clear so no event is lost
    assign ev_d = ((acc.evRd ? 8'h00 : ev_q) | evSet) & esr_pkg::EV_USED;

    // Error queue entry, priority device over execution over command
    assign push_d = cmdEv.devErr | cmdEv.execErr | cmdEv.cmdErr;
    assign code_d = cmdEv.devErr ? cmdEv.devCode :
                    cmdEv.execErr ? esr_pkg::EXE_ERR_CODE :
                    cmdEv.cmdErr ? esr_pkg::CMD_ERR_CODE : code_q;

    // Live operation condition
    always_comb
    begin
        cond_d = esr_pkg::OP_RESET;
        cond_d[esr_pkg::OP_CAL] = act.alignmentInProgress;
        cond_d[esr_pkg::OP_SWEEP] = act.sweepActiveFlag | act.acquisitionActive;
        cond_d[esr_pkg::OP_MEAS] = act.sweepActiveFlag | act.acquisitionActive;
        cond_d[esr_pkg::OP_TRIG] = act.armedWaiting;
        cond_d[esr_pkg::OP_HCOPY] = act.hardcopyBusy;
        cond_d[esr_pkg::OP_RANGE] = act.rangeDone & stopAfterRange;
        cond_d[esr_pkg::OP_ZERO] = 1'b0;
    end
    // Rising edges latch into the event view, held until read
    assign rise = opMasked(cond_d & ~cond_q);
    assign opEv_d = opMasked((acc.opEvRd ? 16'h0000 : opEv_q) | rise);

    // Summary masks take a write of this cycle, so the flag never lags it
    logic [7:0] evMaskNext;
    logic [15:0] opEnNext;
    assign evMaskNext = acc.maskWr ? acc.maskData : mask_q;
    assign opEnNext = acc.opEnWr ? acc.opEnData : opEn_q;

    // State registers; power-on bit comes from reset
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            ev_q <= esr_pkg::EV_RESET;
            mask_q <= esr_pkg::MASK_RESET;
            opEn_q <= esr_pkg::OP_RESET;
            cond_q <= esr_pkg::OP_RESET;
            opEv_q <= esr_pkg::OP_RESET;
            opcWait_q <= 1'b0;
            key_q <= 1'b0;
            push_q <= 1'b0;
            code_q <= '0;
            evSum_q <= 1'b0;
            opSum_q <= 1'b0;
        end
        else
        begin
            ev_q <= ev_d;
            if (acc.maskWr)
                mask_q <= acc.maskData;
            if (acc.opEnWr)
                opEn_q <= acc.opEnData;
            cond_q <= opMasked(cond_d);
            opEv_q <= opEv_d;
            opcWait_q <= opcWait_d;
            key_q <= localKey;
            push_q <= push_d;
            code_q <= code_d;
            evSum_q <= |(ev_d & evMaskNext);
            opSum_q <= |(opEv_d & opEnNext);
        end
    end

    // Read views come straight from flops
    assign eventStatusLatch = ev_q;
    assign eventStatusMask = mask_q;
    assign opCondition = cond_q;
    assign opEvent = opEv_q;
    assign opEnable = opEn_q;
    assign eventSummaryFlag = evSum_q;
    assign opSummary = opSum_q;
    assign errPush = push_q;
    assign errCode = code_q;

    // Checks; registered views trail the inputs by one clock

    // Steps of the completion handshake
    sequence opcArmed;
        cmdEv.opcReq && !pendingDone;
    endsequence
    sequence opcWaiting;
        opcWait_q && !pendingDone;
    endsequence
    sequence opcReleased;
        opcWait_q && pendingDone;
    endsequence

    // Fresh request with work outstanding must not set the bit
    chk_opc_wait: assert property (@(posedge core_clk) disable iff (!rstn)
        opcArmed ##0 !opcWait_q |=> ev_q[0] == ($past(ev_q[0]) && !$past(acc.evRd)))
        else $error("completion set early");

    // Request with work outstanding is remembered
    chk_opc_armed: assert property (@(posedge core_clk) disable iff (!rstn)
        opcArmed |=> opcWait_q)
        else $error("completion request dropped");

    // Still waiting, so the bit stays clear
    chk_opc_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        opcWaiting ##0 !ev_q[0] |=> !ev_q[0])
        else $error("completion set while waiting");

    // Work done releases the pending request into the bit
    chk_opc_late: assert property (@(posedge core_clk) disable iff (!rstn)
        opcReleased |=> ev_q[0] && !opcWait_q)
        else $error("completion not released");

    // Nothing outstanding: bit on the next clock
    chk_opc_now: assert property (@(posedge core_clk) disable iff (!rstn)
        cmdEv.opcReq && pendingDone |=> ev_q[0])
        else $error("completion missing");

    // Either query fault sets the query bit
    chk_query_set: assert property (@(posedge core_clk) disable iff (!rstn)
        cmdEv.readNoQuery || cmdEv.unreadOverrun |=> ev_q[2])
        else $error("query bit missing");

    // Device error carries its own code
    chk_dev_push: assert property (@(posedge core_clk) disable iff (!rstn)
        cmdEv.devErr |=> ev_q[3] && errPush && errCode == $past(cmdEv.devCode))
        else $error("device error not pushed");

    // Execution error queues the fixed execution code
    chk_exec_push: assert property (@(posedge core_clk) disable iff (!rstn)
        cmdEv.execErr && !cmdEv.devErr |=> ev_q[4] && errPush && errCode == esr_pkg::EXE_ERR_CODE)
        else $error("exec error wrong");

    // Command error queues the fixed command code
    chk_cmd_push: assert property (@(posedge core_clk) disable iff (!rstn)
        cmdEv.cmdErr && !cmdEv.devErr && !cmdEv.execErr |=> ev_q[5] && errPush
        && errCode == esr_pkg::CMD_ERR_CODE)
        else $error("cmd error wrong");

    // No error, no queue entry
    chk_push_idle: assert property (@(posedge core_clk) disable iff (!rstn)
        !cmdEv.devErr && !cmdEv.execErr && !cmdEv.cmdErr |=> !errPush)
        else $error("spurious queue entry");

    // Local key press latches the user request
    chk_key_edge: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(localKey) |=> ev_q[6])
        else $error("user request lost");

    // First clock out of reset shows the power-on event
    chk_power_on: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(rstn) |-> eventStatusLatch == esr_pkg::EV_RESET)
        else $error("power-on event missing");

    // Mask takes the written value
    chk_mask_write: assert property (@(posedge core_clk) disable iff (!rstn)
        acc.maskWr |=> mask_q == $past(acc.maskData))
        else $error("mask not written");

    // Calibration bit follows the activity
    chk_cal_follow: assert property (@(posedge core_clk) disable iff (!rstn)
        1'b1 |=> opCondition[0] == $past(act.alignmentInProgress))
        else $error("calibration bit wrong");

    // Sweep and measure bits twin, top bit zero
    chk_meas_pair: assert property (@(posedge core_clk) disable iff (!rstn)
        opCondition[3] == opCondition[4] && !opCondition[15] && !opEvent[15])
        else $error("sweep bits differ");

    // Trigger wait bit follows the armed state
    chk_trig_follow: assert property (@(posedge core_clk) disable iff (!rstn)
        1'b1 |=> opCondition[5] == $past(act.armedWaiting))
        else $error("trigger bit wrong");

    // Hardcopy bit follows the print job
    chk_hcopy_follow: assert property (@(posedge core_clk) disable iff (!rstn)
        1'b1 |=> opCondition[8] == $past(act.hardcopyBusy))
        else $error("hardcopy bit wrong");

    // Range bit only with the option on
    chk_range_follow: assert property (@(posedge core_clk) disable iff (!rstn)
        1'b1 |=> opCondition[10] == ($past(act.rangeDone) && $past(stopAfterRange)))
        else $error("range bit wrong");

    // Event view keeps an ended activity until read
    chk_op_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        opEvent[0] && !acc.opEvRd |=> opEvent[0])
        else $error("op event lost");

    // Event latch read clears when nothing new arrives
    chk_read_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        acc.evRd && evSet == 8'h00 |=> ev_q == 8'h00)
        else $error("read did not clear");

    // Operation event read clears when nothing new arrives
    chk_op_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        acc.opEvRd && rise == 16'h0000 |=> opEvent == 16'h0000)
        else $error("op read did not clear");

    // Event summary matches latch and mask
    chk_sum_flag: assert property (@(posedge core_clk) disable iff (!rstn)
        ##1 eventSummaryFlag == |(ev_q & mask_q))
        else $error("summary wrong");

    // Operation summary matches events and enables
    chk_op_sum: assert property (@(posedge core_clk) disable iff (!rstn)
        ##1 opSummary == |(opEv_q & opEn_q))
        else $error("op summary wrong");

    // Unused positions never show up
    chk_unused_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        (eventStatusLatch & ~esr_pkg::EV_USED) == 8'h00
        && (opCondition & ~esr_pkg::OP_USED) == 16'h0000
        && (opEvent & ~esr_pkg::OP_USED) == 16'h0000)
        else $error("unused bit set");

    // Every rising edge lands in the event view, even with a read
    chk_op_rise: assert property (@(posedge core_clk) disable iff (!rstn)
        1'b1 |=> (opEvent & $past(rise)) == $past(rise))
        else $error("rising edge not latched");
endmodule

// ---- dv/esr_host_model.sv ----
// Remote controller model driving command events and register accesses
`timescale 1ns/1ps
module esr_host_model
(
    // Clock
    input wire logic core_clk,
    // Command channel and register access
    output esr_pkg::esr_cmd_s cmdEv,
    output esr_pkg::esr_acc_s acc
);
    // Idle at time zero so no strobe floats
    initial
    begin
        cmdEv = '0;
        acc = '0;
    end

    // One-cycle command strobe; code turns to junk once released
    task automatic send_cmd(input esr_pkg::esr_cmd_s c);
        @(posedge core_clk);
        cmdEv <= c;
        @(posedge core_clk);
        cmdEv <= '{devCode: ~c.devCode, default: '0};
        #1;
    endtask

    // Mask write, enable write or clearing read of a view
    task automatic send_acc(input esr_pkg::esr_acc_s a);
        @(posedge core_clk);
        acc <= a;
        @(posedge core_clk);
        acc <= '{maskData: ~a.maskData, opEnData: ~a.opEnData, default: '0};
        #1;
    endtask
endmodule

// ---- dv/tb_event_status_reporting.sv ----
// Self-checking bench for the status core
`timescale 1ns/1ps
module tb_event_status_reporting;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic pendingDone = 1'b1;
    logic localKey = 1'b0;
    logic stopAfterRange = 1'b0;
    esr_pkg::esr_act_s act = '0;
    esr_pkg::esr_cmd_s cmdEv;
    esr_pkg::esr_acc_s acc;
    logic [7:0] latch, mask;
    logic [15:0] opCond, opEv, opEn;
    logic summary, opSum, errPush;
    logic signed [15:0] errCode;
    int nMismatch = 0;
    int testsRun = 0;

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    esr_host_model host (.core_clk(core_clk), .cmdEv(cmdEv), .acc(acc));
    esr_status_core dut (.core_clk(core_clk), .rstn(rstn), .cmdEv(cmdEv),
        .pendingDone(pendingDone), .localKey(localKey), .act(act),
        .stopAfterRange(stopAfterRange), .acc(acc), .eventStatusLatch(latch),
        .eventStatusMask(mask), .opCondition(opCond), .opEvent(opEv), .opEnable(opEn),
        .eventSummaryFlag(summary), .opSummary(opSum), .errPush(errPush), .errCode(errCode));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("mismatches %0d, comparisons %0d", nMismatch, testsRun);
        if (nMismatch == 0 && testsRun > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Clearing read of the event latch
    task automatic clear_ev();
        host.send_acc('{evRd: 1'b1, default: '0});
        chk(16'(latch), 16'h0000);
    endtask

    // Each error kind with its bit, queue code and masked summary
    task automatic t_errors();
        logic [15:0] code [5] = '{16'hFEA2, 16'hFF38, 16'hFF9C, 16'h0000, 16'h0000};
        logic [7:0] bitv [5] = '{8'h08, 8'h10, 8'h20, 8'h04, 8'h04};
        esr_pkg::esr_cmd_s c;
        host.send_acc('{maskWr: 1'b1, maskData: 8'h08, default: '0});
        chk(16'(mask), 16'h0008);
        for (int i = 0; i < 5; i++)
        begin
            c = '{devCode: code[0], default: '0};
            c.devErr = (i == 0);
            c.execErr = (i == 1);
            c.cmdErr = (i == 2);
            c.readNoQuery = (i == 3);
            c.unreadOverrun = (i == 4);
            host.send_cmd(c);
            chk(16'(latch), 16'(bitv[i]));
            chk(16'(errPush), 16'(i < 3));
            if (i < 3)
                chk(errCode, code[i]);
            chk(16'(summary), 16'(i == 0));
            clear_ev();
        end
    endtask

    // Completion waits for earlier commands; local key edge only
    task automatic t_opc_key();
        @(posedge core_clk) pendingDone <= 1'b0;
        host.send_cmd('{opcReq: 1'b1, default: '0});
        repeat (3) @(posedge core_clk);
        #1 chk(16'(latch), 16'h0000);
        @(posedge core_clk) pendingDone <= 1'b1;
        @(posedge core_clk);
        #1 chk(16'(latch), 16'h0001);
        clear_ev();
        @(posedge core_clk) localKey <= 1'b1;
        @(posedge core_clk);
        #1 chk(16'(latch), 16'h0040);
        clear_ev();
        repeat (2) @(posedge core_clk);
        #1 chk(16'(latch), 16'h0000);
        @(posedge core_clk) localKey <= 1'b0;
    endtask

    // Condition view, held events, enable summary, range flag
    task automatic t_operation();
        host.send_acc('{opEnWr: 1'b1, opEnData: 16'h0001, default: '0});
        chk(opEn, 16'h0001);
        @(posedge core_clk) act <= '{sweepActiveFlag: 1'b1, default: '0};
        @(posedge core_clk);
        #1 chk(opCond, 16'h0018);
        @(posedge core_clk) act <= '{rangeDone: 1'b0, default: 1'b1};
        @(posedge core_clk);
        #1 chk(opCond, 16'h0139);
        @(posedge core_clk) act <= '0;
        repeat (2) @(posedge core_clk);
        #1 chk(opCond, 16'h0000);
        chk(opEv, 16'h0139);
        chk(16'(opSum), 16'h0001);
        host.send_acc('{opEvRd: 1'b1, default: '0});
        @(posedge core_clk);
        #1 chk(opEv, 16'h0000);
        chk(16'(opSum), 16'h0000);
        for (int s = 0; s < 2; s++)
        begin
            @(posedge core_clk) stopAfterRange <= s[0];
            act.rangeDone <= 1'b1;
            @(posedge core_clk) act.rangeDone <= 1'b0;
            repeat (2) @(posedge core_clk);
            #1 chk(opEv, s ? 16'h0400 : 16'h0000);
        end
    endtask

    // Watchdog well beyond the fewer than one hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge core_clk);
        nMismatch++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        #1 chk(16'(latch), 16'h0080);
        chk(16'(mask), 16'h0000);
        clear_ev();
        t_errors();
        t_opc_key();
        t_operation();
        end_sim();
    end
endmodule
